// ---- design/slif_pkg.sv ----
package slif_pkg;
  // Printed offsets are register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_STATUS_CTRL   = 8'h0e;
  localparam logic [7:0]  IDX_THRESHOLD     = 8'h0f;
  localparam logic [11:0] ADDR_STATUS_CTRL  = 12'h038;
  localparam logic [11:0] ADDR_THRESHOLD    = 12'h03c;
  localparam logic [11:0] ADDR_ROUTE        = 12'h040;
  localparam int          BIT_SRC_EN        = 3;
  localparam int          BIT_SIGNAL_FLAG   = 2;
  localparam int          BIT_LOCK_FLAG     = 1;
  localparam int          BIT_LOCK_PIN_EN   = 0;
  localparam int          BIT_ROUTE_A       = 0;
  localparam int          BIT_ROUTE_B       = 1;
  localparam logic        RST_SRC_EN        = 1'b0;
  localparam logic        RST_LOCK_PIN_EN   = 1'b1;
  localparam logic [7:0]  RST_THRESHOLD     = 8'h00;
  localparam logic [1:0]  RST_ROUTE         = 2'h0;
  typedef enum logic [1:0] {
    SLIF_IDLE   = 2'b00,
    SLIF_ACCESS = 2'b01
  } slif_apb_state_t;
endpackage

// ---- design/slif_flag_if.sv ----
`timescale 1ns/1ps
interface slif_flag_if;
  logic set_evt;
  logic clr_wr;
  logic flag;
  modport owner (input set_evt, input clr_wr, output flag);
  modport user  (output set_evt, output clr_wr, input flag);
endinterface

// ---- design/slif_sticky_flag.sv ----
`timescale 1ns/1ps
module slif_sticky_flag (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  slif_flag_if.owner  fl
);
  // Set wins over a simultaneous write-one clear so no event is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fl.flag <= 1'b0;
    end else if (fl.set_evt) begin
      fl.flag <= 1'b1;
    end else if (fl.clr_wr) begin
      fl.flag <= 1'b0;
    end
  end
endmodule

// ---- design/slif_signal_lock_irq_flags.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Set signal-level flag when measured strength exceeds the threshold.
// - Writing one to the signal-level flag clears it; flag is readable.
// - Lock flag reads 0 while unlocked, 1 once the synthesizer has locked; code sets it on the lock rising edge and holds it until a write-one clear.
// - Writing one to the lock flag clears it to acknowledge lock.
// - Lock pin floats when enable is 0; carries lock when 1 (default).
// - Threshold is 8 bits, same coding as the strength value.
// - Signal-level source may route to output a, b, both, or neither.
module slif_signal_lock_irq_flags
  import slif_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  signal_strength,
  input  wire logic        synth_locked,
  output logic             lock_pin_o,
  output logic             lock_pin_oe,
  output logic             irq_out_a,
  output logic             irq_out_b
);
  logic [7:0]      strength_s1;
  logic [7:0]      strength_s2;
  logic [7:0]      strength_s3;
  logic [7:0]      strength_q;
  logic            locked_s1;
  logic            locked_s2;
  logic            locked_d;
  logic            src_en;
  logic            lock_pin_en;
  logic [7:0]      signal_level_threshold;
  logic [1:0]      route;
  logic            wr_take;
  logic            rd_take;
  logic            addr_ok;
  logic            clr_byte;
  logic [31:0]     next_prdata;
  slif_apb_state_t apb_state;

  slif_flag_if sig_fl ();
  slif_flag_if lock_fl ();

  // Pins come from the analog side, so they are synchronised first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strength_s1 <= 8'h00;
      strength_s2 <= 8'h00;
      locked_s1   <= 1'b0;
      locked_s2   <= 1'b0;
      locked_d    <= 1'b0;
    end else begin
      strength_s1 <= signal_strength;
      strength_s2 <= strength_s1;
      locked_s1   <= synth_locked;
      locked_s2   <= locked_s1;
      locked_d    <= locked_s2;
    end
  end

  // The strength code is a multi-bit word from another domain: bits may land in
  // different cycles, so a value is only used once it has stood for two samples
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strength_s3 <= 8'h00;
      strength_q  <= 8'h00;
    end else begin
      strength_s3 <= strength_s2;
      if (strength_s2 == strength_s3) begin
        strength_q <= strength_s3;
      end
    end
  end

  assign addr_ok  = (paddr == ADDR_STATUS_CTRL) || (paddr == ADDR_THRESHOLD) ||
                    (paddr == ADDR_ROUTE);
  assign wr_take  = (apb_state == SLIF_ACCESS) && psel && penable && pwrite;
  assign rd_take  = (apb_state == SLIF_ACCESS) && psel && penable && !pwrite;
  assign clr_byte = wr_take && pstrb[0] && (paddr == ADDR_STATUS_CTRL);

  // Strict compare, same coding on both sides; source enable gates it
  assign sig_fl.set_evt  = src_en && (strength_q > signal_level_threshold);
  assign sig_fl.clr_wr   = clr_byte && pwdata[BIT_SIGNAL_FLAG];
  // Lock flag sets on the rising edge of lock, so a write-one clear sticks
  assign lock_fl.set_evt = locked_s2 && !locked_d;
  assign lock_fl.clr_wr  = clr_byte && pwdata[BIT_LOCK_FLAG];

  slif_sticky_flag u_sig_flag (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .fl      (sig_fl)
  );

  slif_sticky_flag u_lock_flag (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .fl      (lock_fl)
  );

  // No wait states: answer in the cycle after the setup phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      apb_state <= SLIF_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      case (apb_state)
        SLIF_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (psel && !penable) begin
            apb_state <= SLIF_ACCESS;
            pready    <= 1'b1;
            pslverr   <= !addr_ok;
          end
        end
        SLIF_ACCESS: begin
          apb_state <= SLIF_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
        default: begin
          apb_state <= SLIF_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_en                 <= RST_SRC_EN;
      lock_pin_en            <= RST_LOCK_PIN_EN;
      signal_level_threshold <= RST_THRESHOLD;
      route                  <= RST_ROUTE;
    end else if (wr_take && pstrb[0]) begin
      if (paddr == ADDR_STATUS_CTRL) begin
        src_en      <= pwdata[BIT_SRC_EN];
        lock_pin_en <= pwdata[BIT_LOCK_PIN_EN];
      end
      if (paddr == ADDR_THRESHOLD) begin
        signal_level_threshold <= pwdata[7:0];
      end
      if (paddr == ADDR_ROUTE) begin
        route <= pwdata[1:0];
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == ADDR_STATUS_CTRL) begin
      next_prdata[BIT_SRC_EN]      = src_en;
      next_prdata[BIT_SIGNAL_FLAG] = sig_fl.flag;
      next_prdata[BIT_LOCK_FLAG]   = lock_fl.flag;
      next_prdata[BIT_LOCK_PIN_EN] = lock_pin_en;
    end else if (paddr == ADDR_THRESHOLD) begin
      next_prdata[7:0] = signal_level_threshold;
    end else if (paddr == ADDR_ROUTE) begin
      next_prdata[1:0] = route;
    end
  end

  // Read data is captured with pready so it is valid at the sampling edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_state == SLIF_IDLE && psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end else if (rd_take) begin
      prdata <= 32'h0000_0000;
    end
  end

  // Outputs registered; pin enable drops to float the pin when disabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_pin_o  <= 1'b0;
      lock_pin_oe <= 1'b0;
      irq_out_a   <= 1'b0;
      irq_out_b   <= 1'b0;
    end else begin
      lock_pin_o  <= lock_pin_en && locked_s2;
      lock_pin_oe <= lock_pin_en;
      irq_out_a   <= sig_fl.flag && route[BIT_ROUTE_A];
      irq_out_b   <= sig_fl.flag && route[BIT_ROUTE_B];
    end
  end
endmodule

// ---- bench/slif_signal_lock_irq_flags_sva.sv ----
`timescale 1ns/1ps
module slif_signal_lock_irq_flags_sva
  import slif_pkg::*;
(
  input wire logic        clk_sys, rst_n, psel, penable, pwrite, synth_locked,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb,
  input wire logic [7:0]  signal_strength,
  input wire logic        pready, pslverr, lock_pin_o, lock_pin_oe, irq_out_a, irq_out_b
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_ctl_wr; psel && penable && pready && pwrite && paddr == ADDR_STATUS_CTRL && pstrb[0]; endsequence
  sequence s_idle; !psel && !$past(psel); endsequence
  property p_answer; s_setup |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_quiet; !$past(psel) |-> !pready; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_pin; lock_pin_o |-> lock_pin_oe; endproperty
  a_pin: assert property (p_pin) else $error("lock pin driven while floating");
  property p_oe_on; s_ctl_wr ##0 pwdata[0] |-> ##[1:2] lock_pin_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin enable not applied");
  property p_oe_off; s_ctl_wr ##0 !pwdata[0] |-> ##[1:2] !lock_pin_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin disable not applied");
  property p_hold_a; irq_out_a ##0 s_idle |=> irq_out_a; endproperty
  a_hold_a: assert property (p_hold_a) else $error("output a dropped alone");
  property p_hold_b; irq_out_b ##0 s_idle |=> irq_out_b; endproperty
  a_hold_b: assert property (p_hold_b) else $error("output b dropped alone");
endmodule
bind slif_signal_lock_irq_flags slif_signal_lock_irq_flags_sva u_slif_signal_lock_irq_flags_sva (.*);

// ---- bench/slif_signal_lock_irq_flags_bench.sv ----
`timescale 1ns/1ps
module slif_signal_lock_irq_flags_bench;
  import slif_pkg::*;
  logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, synth_locked = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [3:0]  pstrb = 4'hf;
  logic [7:0]  signal_strength = 0;
  logic        pready, pslverr, lock_pin_o, lock_pin_oe, irq_out_a, irq_out_b, e;
  int          miscompares = 0, compares = 0;
  // Threshold, strength, expected flag
  logic [16:0] rows [6] = '{{8'h0a, 8'h0b, 1'b1}, {8'h0a, 8'h0a, 1'b0}, {8'h0a, 8'h09, 1'b0},
                            {8'hff, 8'hff, 1'b0}, {8'h00, 8'h01, 1'b1}, {8'hfe, 8'hff, 1'b1}};
  slif_signal_lock_irq_flags u_slif_signal_lock_irq_flags (.*);
  initial forever #10 clk_sys = ~clk_sys;
  task chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, pready, 1'b1);
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1;
    apb(0, ADDR_STATUS_CTRL, 0);
    chk(q, 32'h1);
    apb(0, ADDR_THRESHOLD, 0);
    chk(q, 32'h0);
    apb(0, 12'h044, 0);
    chk({q[30:0], e}, 32'h1);
    chk(lock_pin_oe, 1);
    foreach (rows[i]) begin
      signal_strength <= rows[i][8:1];
      apb(1, ADDR_THRESHOLD, rows[i][16:9]);
      apb(0, ADDR_THRESHOLD, 0);
      chk(q, rows[i][16:9]);
      apb(1, ADDR_STATUS_CTRL, 32'hd);
      repeat (2) @(posedge clk_sys);
      apb(0, ADDR_STATUS_CTRL, 0);
      chk(q[2], rows[i][0]);
    end
    for (int r = 0; r < 4; r++) begin
      apb(1, ADDR_ROUTE, r);
      repeat (3) @(posedge clk_sys);
      chk({irq_out_b, irq_out_a}, r);
    end
    signal_strength <= 8'h00;
    repeat (4) @(posedge clk_sys);
    apb(0, ADDR_STATUS_CTRL, 0);
    chk(q[2], 1);
    apb(1, ADDR_STATUS_CTRL, 32'hd);
    apb(0, ADDR_STATUS_CTRL, 0);
    chk(q[2], 0);
    // A write with byte lane 0 off must leave the threshold alone
    pstrb <= 4'h0;
    apb(1, ADDR_THRESHOLD, 32'h55);
    pstrb <= 4'hf;
    apb(0, ADDR_THRESHOLD, 0);
    chk(q, 32'hfe);
    synth_locked <= 1;
    repeat (5) @(posedge clk_sys);
    chk(lock_pin_o, 1);
    apb(0, ADDR_STATUS_CTRL, 0);
    chk(q[1], 1);
    // Clearing the lock event while still locked must stay cleared
    apb(1, ADDR_STATUS_CTRL, 32'h2);
    apb(0, ADDR_STATUS_CTRL, 0);
    chk(q, 32'h0);
    chk(lock_pin_oe, 0);
    final_report;
  end
endmodule
